// [rtl/timer_gate_top.sv]
// timer unit with gate pulse, status and axi4-lite registers
`timescale 1ns/10ps
`default_nettype none
module timer_gate_top (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic slow_mode,
  input wire logic high_freq_tick,
  input wire logic low_freq_tick,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic timer_interrupt,
  output logic gate_pulse
);
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  logic [7:0] gate_control_reg, gate_control_next;
  logic [7:0] mode_control_reg, mode_control_next;
  logic [15:0] compare_reg, compare_next;
  logic [7:0] gate_period_reg, gate_period_next;
  logic [2:0] irq_status_reg, irq_status_next;
  logic [2:0] irq_mask_reg, irq_mask_next;
  logic [15:0] count_reg, count_next;
  logic overflow_reg, overflow_next;
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [7:0] waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  logic running;
  logic gate_on;
  logic unit_tick;
  logic gate_level;
  logic gate_rise;
  logic gate_fall;
  logic count_tick;
  logic match;
  logic gate_event;
  logic [2:0] events;
  logic do_write;
  logic [7:0] wbyte;
  logic [7:0] status_byte;

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = a == timer_gate_pkg::mode_control_addr ||
                 a == timer_gate_pkg::compare_addr ||
                 a == timer_gate_pkg::gate_period_addr ||
                 a == timer_gate_pkg::irq_status_addr ||
                 a == timer_gate_pkg::irq_mask_addr ||
                 a == timer_gate_pkg::gate_control_addr ||
                 a == timer_gate_pkg::timer_status_addr;
  endfunction

  // merge one byte lane into an old value
  function automatic logic [7:0] lane(input logic [7:0] old,
                                      input logic [7:0] nw,
                                      input logic en);
    lane = en ? nw : old;
  endfunction

  // run state: start code 10 runs, anything else stops
  always_comb begin
    running = mode_control_reg[timer_gate_pkg::start_control_pos +: 2]
              == timer_gate_pkg::start_run;
    gate_on = running && gate_control_reg
              [timer_gate_pkg::gate_pulse_select_pos +: 2]
              == timer_gate_pkg::gate_internal;
  end

  gate_unit_prescaler u_prescaler (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .run(gate_on),
    .slow_mode(slow_mode),
    .high_freq_tick(high_freq_tick),
    .low_freq_tick(low_freq_tick),
    .unit_select(gate_control_reg[timer_gate_pkg::gate_time_unit_pos +: 2]),
    .unit_tick(unit_tick)
  );

  gate_pulse_gen u_gate (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .run(gate_on),
    .unit_tick(unit_tick),
    .gate_high_field(gate_period_reg[7:4]),
    .gate_low_field(gate_period_reg[3:0]),
    .gate_level(gate_level),
    .gate_rise(gate_rise),
    .gate_fall(gate_fall)
  );

  // counter: only timer mode is modelled; other modes hold the count
  always_comb begin
    count_tick = running && (slow_mode ? low_freq_tick : high_freq_tick);
    match = 1'b0;
    count_next = count_reg;
    overflow_next = overflow_reg;
    if (!running) begin
      count_next = 16'h0000;
      overflow_next = 1'b0;
    end else if (count_tick && mode_control_reg[1:0] ==
                 timer_gate_pkg::mode_timer) begin
      if (count_reg == compare_reg) begin
        match = 1'b1;
        count_next = 16'h0000;
      end else if (count_reg == 16'hffff) begin
        count_next = 16'h0000;
        overflow_next = 1'b1;
      end else begin
        count_next = count_reg + 16'h0001;
      end
    end
    gate_event = gate_control_reg[timer_gate_pkg::gate_irq_edge_pos]
                 ? gate_fall : gate_rise;
    events = 3'h0;
    events[timer_gate_pkg::irq_match_bit] = match;
    events[timer_gate_pkg::irq_gate_bit] = gate_event;
    events[timer_gate_pkg::irq_overflow_bit] = overflow_next && !overflow_reg;
    status_byte = 8'h00;
    status_byte[timer_gate_pkg::running_pos] = gate_on && gate_level;
    status_byte[timer_gate_pkg::overflow_pos] = overflow_reg;
  end

  // axi4-lite write path; address and data may arrive in either order
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    s_axi_awready = !aw_held_reg && !bvalid_reg;
    s_axi_wready = !w_held_reg && !bvalid_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      waddr_next = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = known_addr(waddr_reg) ? resp_okay : resp_slverr;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    wbyte = wdata_reg[7:0];
    gate_control_next = gate_control_reg;
    mode_control_next = mode_control_reg;
    compare_next = compare_reg;
    gate_period_next = gate_period_reg;
    irq_mask_next = irq_mask_reg;
    irq_status_next = irq_status_reg;
    if (do_write) begin
      unique case (waddr_reg)
        timer_gate_pkg::gate_control_addr:
          // fixed bits forced so a careless write cannot break them
          gate_control_next = (lane(gate_control_reg, wbyte, wstrb_reg[0])
                               & timer_gate_pkg::gate_control_keep_mask)
                              | timer_gate_pkg::gate_control_fixed;
        timer_gate_pkg::mode_control_addr:
          mode_control_next = lane(mode_control_reg, wbyte, wstrb_reg[0]);
        timer_gate_pkg::compare_addr: begin
          compare_next[7:0] = lane(compare_reg[7:0], wbyte, wstrb_reg[0]);
          compare_next[15:8] = lane(compare_reg[15:8], wdata_reg[15:8],
                                    wstrb_reg[1]);
        end
        timer_gate_pkg::gate_period_addr:
          gate_period_next = lane(gate_period_reg, wbyte, wstrb_reg[0]);
        timer_gate_pkg::irq_mask_addr:
          if (wstrb_reg[0]) begin
            irq_mask_next = wbyte[2:0];
          end
        timer_gate_pkg::irq_status_addr:
          if (wstrb_reg[0]) begin
            irq_status_next = irq_status_reg & ~wbyte[2:0];
          end
        default: ; // status register and unmapped: no effect
      endcase
    end
    // set wins over a simultaneous clear
    irq_status_next = irq_status_next | events;
  end

  // axi4-lite read path
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    s_axi_arready = !rvalid_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = resp_okay;
      rdata_next = 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
        timer_gate_pkg::gate_control_addr:
          rdata_next[7:0] = gate_control_reg;
        timer_gate_pkg::timer_status_addr: rdata_next[7:0] = status_byte;
        timer_gate_pkg::mode_control_addr:
          rdata_next[7:0] = mode_control_reg;
        timer_gate_pkg::compare_addr: rdata_next[15:0] = count_reg;
        timer_gate_pkg::gate_period_addr:
          rdata_next[7:0] = gate_period_reg;
        timer_gate_pkg::irq_status_addr: rdata_next[2:0] = irq_status_reg;
        timer_gate_pkg::irq_mask_addr: rdata_next[2:0] = irq_mask_reg;
        default: rresp_next = resp_slverr;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gate_control_reg <= timer_gate_pkg::gate_control_reset;
      mode_control_reg <= timer_gate_pkg::mode_control_reset;
      compare_reg <= timer_gate_pkg::compare_reset;
      gate_period_reg <= timer_gate_pkg::gate_period_reset;
      irq_status_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
      count_reg <= 16'h0000;
      overflow_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
    end else if (clk_en) begin
      gate_control_reg <= gate_control_next;
      mode_control_reg <= mode_control_next;
      compare_reg <= compare_next;
      gate_period_reg <= gate_period_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      count_reg <= count_next;
      overflow_reg <= overflow_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  always_comb begin
    s_axi_bvalid = bvalid_reg;
    s_axi_bresp = bresp_reg;
    s_axi_rvalid = rvalid_reg;
    s_axi_rdata = rdata_reg;
    s_axi_rresp = rresp_reg;
    timer_interrupt = |(irq_status_reg & irq_mask_reg);
    gate_pulse = gate_on && gate_level;
  end
endmodule // timer_gate_top
`default_nettype wire

// [pkg/timer_gate_pkg.sv]
// constants and types for the gate/status timer block
package timer_gate_pkg;
  // register byte addresses
  // these two sit at word indices; byte address is four times the index
  localparam logic [7:0] gate_control_index = 8'h15;
  localparam logic [7:0] timer_status_index = 8'h16;
  localparam logic [7:0] gate_control_addr = {gate_control_index[5:0], 2'b00};
  localparam logic [7:0] timer_status_addr = {timer_status_index[5:0], 2'b00};
  localparam logic [7:0] mode_control_addr = 8'h00;
  localparam logic [7:0] compare_addr = 8'h04;
  localparam logic [7:0] gate_period_addr = 8'h08;
  localparam logic [7:0] irq_status_addr = 8'h0c;
  localparam logic [7:0] irq_mask_addr = 8'h10;
  // gate_control fields
  localparam int gate_pulse_select_pos = 5;
  localparam int gate_irq_edge_pos = 4;
  localparam int gate_time_unit_pos = 2;
  localparam logic [7:0] gate_control_reset = 8'h02;
  localparam logic [7:0] gate_control_keep_mask = 8'h7c;
  localparam logic [7:0] gate_control_fixed = 8'h02;
  // timer_status fields
  localparam int running_pos = 7;
  localparam int overflow_pos = 6;
  // mode_control fields: start_control [7:6], mode [1:0]
  localparam int start_control_pos = 6;
  localparam int mode_pos = 0;
  localparam logic [7:0] mode_control_reset = 8'h00;
  localparam logic [15:0] compare_reset = 16'h0001;
  localparam logic [7:0] gate_period_reset = 8'h00;
  localparam logic [1:0] start_stop = 2'h0;
  localparam logic [1:0] start_run = 2'h2;
  localparam logic [1:0] gate_internal = 2'h1;
  // interrupt bits
  localparam int irq_match_bit = 0;
  localparam int irq_gate_bit = 1;
  localparam int irq_overflow_bit = 2;
  localparam logic [4:0] gate_full_count = 5'h10;
  // power-mode dependent gate time unit exponents
  localparam logic [4:0] fast_unit_exp = 5'h0c;
  localparam logic [4:0] slow_unit_exp = 5'h04;
  typedef enum logic [1:0] {
    mode_timer, mode_reserved, mode_pulse_width, mode_frequency
  } timer_mode_type;
  typedef enum {gate_idle, gate_high, gate_low} gate_state_type;
endpackage

// [rtl/gate_unit_prescaler.sv]
// prescaler producing one pulse per gate time unit
`timescale 1ns/10ps
`default_nettype none
module gate_unit_prescaler (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic run,
  input wire logic slow_mode,
  input wire logic high_freq_tick,
  input wire logic low_freq_tick,
  input wire logic [1:0] unit_select,
  output logic unit_tick
);
  logic [13:0] count_reg;
  logic [13:0] count_next;
  logic src_tick;
  logic [4:0] exp_sel;
  logic [13:0] last;

  always_comb begin
    src_tick = slow_mode ? low_freq_tick : high_freq_tick;
    exp_sel = (slow_mode ? timer_gate_pkg::slow_unit_exp
                         : timer_gate_pkg::fast_unit_exp)
              + {3'h0, unit_select};
    last = 14'((32'h1 << exp_sel) - 32'h1);
    count_next = count_reg;
    unit_tick = 1'b0;
    if (!run) begin
      count_next = 14'h0000;
    end else if (src_tick) begin
      if (count_reg >= last) begin
        count_next = 14'h0000;
        unit_tick = 1'b1;
      end else begin
        count_next = count_reg + 14'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= 14'h0000;
    end else if (clk_en) begin
      count_reg <= count_next;
    end
  end
endmodule // gate_unit_prescaler
`default_nettype wire

// [rtl/gate_pulse_gen.sv]
// internal window gate pulse generator
`timescale 1ns/10ps
`default_nettype none
module gate_pulse_gen (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic run,
  input wire logic unit_tick,
  input wire logic [3:0] gate_high_field,
  input wire logic [3:0] gate_low_field,
  output logic gate_level,
  output logic gate_rise,
  output logic gate_fall
);
  timer_gate_pkg::gate_state_type state_reg, state_next;
  logic [4:0] units_reg;
  logic [4:0] units_next;
  logic [4:0] high_len;
  logic [4:0] low_len;

  always_comb begin
    high_len = timer_gate_pkg::gate_full_count - {1'b0, gate_high_field};
    low_len = timer_gate_pkg::gate_full_count - {1'b0, gate_low_field};
    state_next = state_reg;
    units_next = units_reg;
    gate_rise = 1'b0;
    gate_fall = 1'b0;
    unique case (state_reg)
      timer_gate_pkg::gate_idle: begin
        if (run) begin
          state_next = timer_gate_pkg::gate_high;
          units_next = 5'h00;
          gate_rise = 1'b1;
        end
      end
      timer_gate_pkg::gate_high: begin
        if (unit_tick) begin
          units_next = units_reg + 5'h01;
          if (units_next >= high_len) begin
            state_next = timer_gate_pkg::gate_low;
            units_next = 5'h00;
            gate_fall = 1'b1;
          end
        end
      end
      timer_gate_pkg::gate_low: begin
        if (unit_tick) begin
          units_next = units_reg + 5'h01;
          if (units_next >= low_len) begin
            state_next = timer_gate_pkg::gate_high;
            units_next = 5'h00;
            gate_rise = 1'b1;
          end
        end
      end
    endcase
    if (!run) begin
      state_next = timer_gate_pkg::gate_idle;
      units_next = 5'h00;
      gate_rise = 1'b0;
      gate_fall = 1'b0;
    end
    gate_level = state_reg == timer_gate_pkg::gate_high;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= timer_gate_pkg::gate_idle;
      units_reg <= 5'h00;
    end else if (clk_en) begin
      state_reg <= state_next;
      units_reg <= units_next;
    end
  end
endmodule // gate_pulse_gen
`default_nettype wire

// [test/timer_gate_sva.sv]
// port-level assertions for the timer gate block
`timescale 1ns/10ps
`default_nettype none
module timer_gate_sva (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic gate_pulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [7:0] last_ar;
  // address of the read now answered; arready is low until it is taken
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      last_ar <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      last_ar <= s_axi_araddr;
    end
  end
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("late bvalid");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("late rvalid");
  property p_bvalid_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bvalid_drop: assert property (p_bvalid_drop) else $error("bvalid stuck");
  property p_rvalid_drop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rvalid_drop: assert property (p_rvalid_drop) else $error("rvalid stuck");
  property p_arready_low;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_arready_low: assert property (p_arready_low) else $error("arready early");
  property p_err_zero;
    s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read data");
  property p_mapped_okay;
    s_axi_rvalid && last_ar[1:0] == 2'b00 &&
      (last_ar <= timer_gate_pkg::irq_mask_addr ||
       last_ar == timer_gate_pkg::gate_control_addr ||
       last_ar == timer_gate_pkg::timer_status_addr)
      |-> s_axi_rresp == 2'b00;
  endproperty
  a_mapped_okay: assert property (p_mapped_okay) else $error("bad rresp");
  property p_status_bits;
    s_axi_rvalid && last_ar == timer_gate_pkg::timer_status_addr
      |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[5:0] == 6'h0;
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status bits");
  property p_gate_fixed;
    s_axi_rvalid && last_ar == timer_gate_pkg::gate_control_addr
      |-> s_axi_rdata[31:7] == 25'h0 && s_axi_rdata[1:0] == 2'b10;
  endproperty
  a_gate_fixed: assert property (p_gate_fixed) else $error("fixed bits");
  // shortest phase is one unit of at least sixteen ticks
  property p_gate_min;
    $rose(gate_pulse) |-> gate_pulse [*8];
  endproperty
  a_gate_min: assert property (p_gate_min) else $error("short gate");
endmodule // timer_gate_sva
bind timer_gate_top timer_gate_sva u_sva (
  .sys_clk(sys_clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .gate_pulse(gate_pulse)
);
`default_nettype wire

// [test/timer_gate_top_tb_top.sv]
// self-checking bench for the timer gate block
`timescale 1ns/10ps
`default_nettype none
module timer_gate_top_tb_top;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic slow_mode = 1'b0;
  logic high_freq_tick = 1'b0;
  logic low_freq_tick = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, timer_interrupt, gate_pulse;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [33:0] read_q[$];
  logic [1:0] write_q[$];
  int miscompares = 0;
  int comparisons = 0;
  int i, n, m, unit;
  logic [31:0] seed = 32'he83bd14f;
  logic [15:0] cmp;
  logic [7:0] d;

  timer_gate_top DUT (
    .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
    .slow_mode(slow_mode), .high_freq_tick(high_freq_tick),
    .low_freq_tick(low_freq_tick), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .timer_interrupt(timer_interrupt), .gate_pulse(gate_pulse)
  );

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic fail(input string msg);
    miscompares++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask

  task automatic timeout();
    fail("wait ran out");
    print_verdict();
  endtask

  task automatic check_read(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("bresp %h expected %h", got, exp));
  endtask

  task automatic check_num(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("level %0d expected %0d", got, exp));
  endtask

  // both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    write_q.push_back(r);
    for (n = 0; n < 64; n++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 64) timeout();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    read_q.push_back({r, v});
    for (n = 0; n < 64; n++) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 64) timeout();
  endtask

  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge sys_clk);
      high_freq_tick <= 1'b1;
      @(posedge sys_clk);
      high_freq_tick <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
  endtask

  // m ends as one less than the cycles spent before the level appeared
  task automatic wait_gate(input logic v);
    for (m = 0; m < 20000; m++) begin
      @(posedge sys_clk);
      if (gate_pulse === v) break;
    end
    if (m == 20000) timeout();
  endtask

  always @(posedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      if (read_q.size() == 0) fail("read without request");
      else check_read({s_axi_rresp, s_axi_rdata}, read_q.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready) begin
      if (write_q.size() == 0) fail("write response without request");
      else check_resp(s_axi_bresp, write_q.pop_front());
    end
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(timer_gate_pkg::gate_control_addr, 32'h02, 2'b00);
    rd(timer_gate_pkg::timer_status_addr, 32'h00, 2'b00);
    wr(timer_gate_pkg::timer_status_addr, 32'hff, 2'b00);
    rd(timer_gate_pkg::timer_status_addr, 32'h00, 2'b00);
    wr(8'h1c, 32'h55, 2'b10);
    rd(8'h1c, 32'h0, 2'b10);
    $display("test reset and access done");
    for (i = 0; i < 6; i++) begin
      seed = xorshift(seed);
      d = seed[7:0];
      wr(timer_gate_pkg::gate_control_addr, {24'h0, d}, 2'b00);
      rd(timer_gate_pkg::gate_control_addr, {24'h0, (d &
         timer_gate_pkg::gate_control_keep_mask) |
         timer_gate_pkg::gate_control_fixed}, 2'b00);
    end
    for (i = 0; i < 4; i++) begin
      wr(timer_gate_pkg::mode_control_addr, 32'(i), 2'b00);
      rd(timer_gate_pkg::mode_control_addr, 32'(i), 2'b00);
    end
    wr(timer_gate_pkg::gate_control_addr, 32'h02, 2'b00);
    $display("test control fields done");
    seed = xorshift(seed);
    cmp = 16'h2 + 16'(seed[2:0]);
    wr(timer_gate_pkg::compare_addr, 32'(cmp), 2'b00);
    wr(timer_gate_pkg::irq_mask_addr, 32'h1, 2'b00);
    wr(timer_gate_pkg::mode_control_addr, 32'h80, 2'b00);
    // match is seen on the tick after the count reaches compare
    pulse(cmp);
    rd(timer_gate_pkg::irq_status_addr, 32'h0, 2'b00);
    pulse(1);
    rd(timer_gate_pkg::irq_status_addr, 32'h1, 2'b00);
    check_num(32'(timer_interrupt), 32'h1);
    wr(timer_gate_pkg::irq_mask_addr, 32'h0, 2'b00);
    check_num(32'(timer_interrupt), 32'h0);
    wr(timer_gate_pkg::irq_mask_addr, 32'h1, 2'b00);
    wr(timer_gate_pkg::irq_status_addr, 32'h1, 2'b00);
    check_num(32'(timer_interrupt), 32'h0);
    pulse(cmp + 1);
    rd(timer_gate_pkg::irq_status_addr, 32'h1, 2'b00);
    wr(timer_gate_pkg::mode_control_addr, 32'h00, 2'b00);
    $display("test timer match done");
    wr(timer_gate_pkg::gate_period_addr, 32'hef, 2'b00);
    for (i = 0; i < 4; i++) begin
      // last pass runs in the fast power mode at the finest unit (unit select 0)
      unit = (i == 3) ? 4096 : (16 << i);
      slow_mode <= (i != 3);
      low_freq_tick <= (i != 3);
      high_freq_tick <= (i == 3);
      wr(timer_gate_pkg::mode_control_addr, 32'h00, 2'b00);
      wr(timer_gate_pkg::gate_control_addr,
         32'h22 | (32'(i % 3) << 2), 2'b00);
      wr(timer_gate_pkg::mode_control_addr, 32'h80, 2'b00);
      wait_gate(1'b1);
      wait_gate(1'b0);
      wait_gate(1'b1);
      check_num(32'(m + 1), 32'(unit));
      wait_gate(1'b0);
      check_num(32'(m + 1), 32'(2 * unit));
    end
    wait_gate(1'b1);
    rd(timer_gate_pkg::timer_status_addr, 32'h80, 2'b00);
    wait_gate(1'b0);
    rd(timer_gate_pkg::timer_status_addr, 32'h00, 2'b00);
    $display("test gate pulse done");
    for (i = 2; i < 4; i++) begin
      wr(timer_gate_pkg::mode_control_addr, 32'h00, 2'b00);
      wr(timer_gate_pkg::gate_control_addr, 32'h02 | (32'(i) << 5), 2'b00);
      wr(timer_gate_pkg::mode_control_addr, 32'h80, 2'b00);
      m = 0;
      repeat (100) begin
        @(posedge sys_clk);
        if (gate_pulse !== 1'b0) m++;
      end
      check_num(32'(m), 32'h0);
    end
    $display("test reserved select done");
    slow_mode <= 1'b1;
    low_freq_tick <= 1'b1;
    wr(timer_gate_pkg::mode_control_addr, 32'h00, 2'b00);
    wr(timer_gate_pkg::gate_control_addr, 32'h32, 2'b00);
    wr(timer_gate_pkg::irq_status_addr, 32'h7, 2'b00);
    // mode 01 keeps the counter still so only gate edges set status
    wr(timer_gate_pkg::mode_control_addr, 32'h81, 2'b00);
    wait_gate(1'b1);
    rd(timer_gate_pkg::irq_status_addr, 32'h0, 2'b00);
    wait_gate(1'b0);
    rd(timer_gate_pkg::irq_status_addr, 32'h2, 2'b00);
    wr(timer_gate_pkg::mode_control_addr, 32'h00, 2'b00);
    $display("test gate edge done");
    print_verdict();
  end
endmodule // timer_gate_top_tb_top
`default_nettype wire
